// file: pkg/phantom_clock_pkg.sv
// Constants for the ROM-socket phantom clock: key, register layout, timing.
// Assumes a single core_clk at 20 MHz and that the host reaches the socket by reads only.
package phantom_clock_pkg;

  // Unlock key, sent byte 0 first, each byte LSB first
  localparam logic [63:0] UNLOCK_KEY = 64'h5CA33AC55CA33AC5;
  localparam int          KEY_BITS   = 64;
  localparam int          DATA_BITS  = 64;

  // Address bit positions in the socket
  localparam int RW_SEL_BIT = 2;
  localparam int WDATA_BIT  = 0;

  // Register indices in the 64-bit image
  localparam int REG_HUND  = 0;
  localparam int REG_SEC   = 1;
  localparam int REG_MIN   = 2;
  localparam int REG_HOUR  = 3;
  localparam int REG_DAY   = 4;
  localparam int REG_DATE  = 5;
  localparam int REG_MONTH = 6;
  localparam int REG_YEAR  = 7;

  // Field positions
  localparam int HOUR_MODE_BIT   = 7;
  localparam int HOUR_PM_BIT     = 5;
  localparam int DAY_RST_DIS_BIT = 4;
  localparam int DAY_OSC_OFF_BIT = 5;

  // Reset values of the time image (00:00:00.00, day 1, 01-01-00)
  localparam logic [63:0] TIME_RESET = 64'h0001010100000000;

  // Tick timing: 10 ms resolution at 50 ns per cycle
  localparam int TICK_MS       = 10;
  localparam int CLK_PERIOD_NS = 50;
  localparam int TICK_CYCLES   = (TICK_MS * 1000000) / CLK_PERIOD_NS;

endpackage

// file: hw/bcd_digit_pair.sv
// Two-digit BCD counter step: adds one and wraps from max to min.
// Pure combinational; caller decides when to apply the step.
module bcd_digit_pair (
  input  wire logic [7:0] cur,
  input  wire logic [7:0] max_val,
  input  wire logic [7:0] min_val,
  output logic      [7:0] nxt,
  output logic            wrap
);
  // Wrap compares whole byte so out-of-range writes still recover at the top
  always_comb
  begin
    wrap = (cur >= max_val);
    if (wrap)
      nxt = min_val;
    else if (cur[3:0] >= 4'h9)
      nxt = {cur[7:4] + 4'h1, 4'h0};
    else
      nxt = {cur[7:4], cur[3:0] + 4'h1};
  end
endmodule // bcd_digit_pair

// file: hw/skid_buffer2.sv
// Two-entry buffer with valid/ready on both sides.
// Assumes producer and consumer share core_clk.
module skid_buffer2 #(
  parameter int WIDTH = 1
) (
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  logic [WIDTH-1:0] mem_q [2];
  logic             wp_q;
  logic             rp_q;
  logic [1:0]       cnt_q;
  logic             push;
  logic             pop;

  assign in_ready  = (cnt_q != 2'h2);
  assign out_valid = (cnt_q != 2'h0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem_q[rp_q];

  // Storage and pointers; a stalled reader simply fills both slots
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wp_q     <= 1'b0;
      rp_q     <= 1'b0;
      cnt_q    <= 2'h0;
      mem_q[0] <= '0;
      mem_q[1] <= '0;
    end
    else
    begin
      if (push)
      begin
        mem_q[wp_q] <= in_data;
        wp_q        <= ~wp_q;
      end
      if (pop)
        rp_q <= ~rp_q;
      if (push && !pop)
        cnt_q <= cnt_q + 2'h1;
      else if (pop && !push)
        cnt_q <= cnt_q - 2'h1;
    end
  end
endmodule // skid_buffer2

// file: hw/rom_socket_phantom_clock.sv
// ROM-socket phantom clock: snoops ROM read cycles for a 64-bit key, then
// moves 64 calendar bits serially. Assumes socket pins are asynchronous.
// Notes on behaviour
// R1: Snoop ROM reads; key unlocks clock transfer
// R2: Write data comes from an address line
// R3: Host uses read cycles only
// R4: Host must not fetch from ROM meanwhile
// R5: Host always writes reset-disable bit as one
// R6: Chip enable held off during clock transfer
// R7: Keep hundredths through year counters
// R8: Month ends and leap February handled
// R9: Hour bit 7 selects 12 or 24 hour
// R10: Fastest counter steps every ten milliseconds
// R11: No interrupt outputs
// R12: Key C5 3A A3 5C twice, LSB first
// R13: Addr bit 2 low writes, high reads
// R14: A read cycle resets the key position
// R15: Exactly 64 data bits, registers 0 to 7
// R16: Registers hold BCD within their ranges
// R17: Mismatch freezes matching until a read
// R18: Cycles outside socket do not disturb sequence
// R19: Reset pin aborts unless disabled; time kept
// R20: After 64 data bits release, need key
module rom_socket_phantom_clock #(
  parameter int TICK_COUNT = phantom_clock_pkg::TICK_CYCLES
) (
  input  wire logic core_clk,
  input  wire logic rst_n,
  input  wire logic sock_ce_n,
  input  wire logic sock_oe_n,
  input  wire logic read_write_select_addr_bit,
  input  wire logic serial_write_data_addr_bit,
  input  wire logic clock_reset_pin_n,
  output logic      mem_ce_n,
  output logic      serial_read_data_line,
  output logic      serial_read_data_line_oe_n,
  output logic      clock_unlocked
);
  // Sequencer states
  typedef enum logic [2:0] {
    ST_MATCH = 3'b001,
    ST_DEAD  = 3'b010,
    ST_XFER  = 3'b100
  } seq_state_e;

  seq_state_e  state_q;
  logic [1:0]  ce_sync_q, oe_sync_q, rw_sync_q, wd_sync_q, rstp_sync_q;
  logic        cyc_q;
  logic        own_q;
  logic        cyc_start;
  logic        cyc_end;
  logic        rd_cyc;
  logic        wr_bit;
  logic [5:0]  pos_q;
  logic [63:0] time_q;
  logic        dout_q;
  logic        pin_abort;
  logic [31:0] tick_cnt_q;
  logic        tick;
  logic        wr_valid;
  logic        wr_ready;
  logic        bw_valid;
  logic [6:0]  bw_data;

  // Two-flop synchronisers on every socket pin
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ce_sync_q   <= 2'h3;
      oe_sync_q   <= 2'h3;
      rw_sync_q   <= 2'h0;
      wd_sync_q   <= 2'h0;
      rstp_sync_q <= 2'h3;
    end
    else
    begin
      ce_sync_q   <= {ce_sync_q[0], sock_ce_n};
      oe_sync_q   <= {oe_sync_q[0], sock_oe_n};
      rw_sync_q   <= {rw_sync_q[0], read_write_select_addr_bit};
      wd_sync_q   <= {wd_sync_q[0], serial_write_data_addr_bit};
      rstp_sync_q <= {rstp_sync_q[0], clock_reset_pin_n};
    end
  end

  // A socket cycle needs both strobes low; other addresses never reach here
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      cyc_q <= 1'b0;
    else
      cyc_q <= !ce_sync_q[1] && !oe_sync_q[1]; // R18
  end

  assign cyc_start = !ce_sync_q[1] && !oe_sync_q[1] && !cyc_q; // R1
  assign cyc_end   = cyc_q && (ce_sync_q[1] || oe_sync_q[1]);
  assign rd_cyc    = rw_sync_q[1]; // R13
  assign wr_bit    = wd_sync_q[1]; // R2
  // Reset pin honoured only when the disable bit is clear
  assign pin_abort = !rstp_sync_q[1] && !time_q[8*phantom_clock_pkg::REG_DAY
                     + phantom_clock_pkg::DAY_RST_DIS_BIT]; // R19

  // Key matching and data transfer sequencer
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= ST_MATCH;
      pos_q   <= 6'h00;
    end
    else if (pin_abort)
    begin
      state_q <= ST_MATCH; // R19
      pos_q   <= 6'h00;
    end
    else if (cyc_start)
    begin
      case (state_q)
        ST_MATCH:
        begin
          if (rd_cyc)
            pos_q <= 6'h00; // R14
          else if (wr_bit == phantom_clock_pkg::UNLOCK_KEY[pos_q]) // R12
          begin
            pos_q <= pos_q + 6'h01;
            if (pos_q == 6'h3F)
              state_q <= ST_XFER; // R1
          end
          else
            state_q <= ST_DEAD; // R17
        end
        ST_DEAD:
        begin
          if (rd_cyc)
          begin
            state_q <= ST_MATCH; // R17
            pos_q   <= 6'h00;
          end
        end
        ST_XFER:
        begin
          pos_q <= pos_q + 6'h01; // R15
          if (pos_q == 6'h3F)
            state_q <= ST_MATCH; // R20
        end
        default:
        begin
          state_q <= ST_MATCH;
          pos_q   <= 6'h00;
        end
      endcase
    end
  end

  // Write bits pass the two-entry buffer before landing in the image
  assign wr_valid = cyc_start && (state_q == ST_XFER) && !rd_cyc && !pin_abort;

  skid_buffer2 #(
    .WIDTH (7)
  ) u_wbuf (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .in_data   ({wr_bit, pos_q}),
    .in_valid  (wr_valid),
    .in_ready  (wr_ready),
    .out_data  (bw_data),
    .out_valid (bw_valid),
    .out_ready (!tick)
  );

  // Read data launched at cycle start, held for the whole cycle
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      dout_q <= 1'b0;
    else if (cyc_start && (state_q == ST_XFER) && rd_cyc)
      dout_q <= time_q[pos_q]; // R13
  end

  // Ownership of the current socket cycle; the sequencer leaves the transfer state
  // at the start of the 64th cycle, but that cycle still belongs to the clock
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      own_q <= 1'b0;
    else if (pin_abort || cyc_end)
      own_q <= 1'b0;
    else if (cyc_start && (state_q == ST_XFER))
      own_q <= 1'b1; // R6
  end

  assign serial_read_data_line      = dout_q;
  assign serial_read_data_line_oe_n = !(own_q && rd_cyc); // R13
  // Chip enable gated while the clock owns the socket, the 64th cycle included
  assign mem_ce_n       = sock_ce_n || (state_q == ST_XFER) || own_q; // R6
  assign clock_unlocked = (state_q == ST_XFER);
  // No interrupt output exists on this block // R11

  // 10 ms tick; oscillator stop bit holds the count at zero
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      tick_cnt_q <= 32'h0;
    else if (time_q[8*phantom_clock_pkg::REG_DAY + phantom_clock_pkg::DAY_OSC_OFF_BIT])
      tick_cnt_q <= 32'h0;
    else if (tick)
      tick_cnt_q <= 32'h0;
    else
      tick_cnt_q <= tick_cnt_q + 32'h1;
  end
  assign tick = (tick_cnt_q == 32'(TICK_COUNT - 1)); // R10

  // Calendar next-value logic
  logic [7:0] hu_n, se_n, mi_n, dy_n, dt_n, mo_n, yr_n, hr_n;
  logic       hu_w, se_w, mi_w, dy_w, dt_w, mo_w, yr_w;
  logic [7:0] dim;
  logic [7:0] hr;
  logic       leap;

  assign hr = time_q[31:24];

  bcd_digit_pair u_hu (.cur(time_q[7:0]),   .max_val(8'h99), .min_val(8'h00),
                       .nxt(hu_n), .wrap(hu_w));
  bcd_digit_pair u_se (.cur(time_q[15:8]),  .max_val(8'h59), .min_val(8'h00), // R16
                       .nxt(se_n), .wrap(se_w));
  bcd_digit_pair u_mi (.cur(time_q[23:16]), .max_val(8'h59), .min_val(8'h00),
                       .nxt(mi_n), .wrap(mi_w));
  bcd_digit_pair u_dy (.cur({5'h00, time_q[34:32]}), .max_val(8'h07),
                       .min_val(8'h01), .nxt(dy_n), .wrap(dy_w));
  bcd_digit_pair u_dt (.cur(time_q[47:40]), .max_val(dim), .min_val(8'h01),
                       .nxt(dt_n), .wrap(dt_w));
  bcd_digit_pair u_mo (.cur(time_q[55:48]), .max_val(8'h12), .min_val(8'h01),
                       .nxt(mo_n), .wrap(mo_w));
  bcd_digit_pair u_yr (.cur(time_q[63:56]), .max_val(8'h99), .min_val(8'h00),
                       .nxt(yr_n), .wrap(yr_w));

  // Leap year: BCD year divisible by four (century rule not kept)
  assign leap = time_q[60] ? (time_q[57:56] == 2'h2) : (time_q[57:56] == 2'h0); // R8

  // Days in month
  always_comb
  begin
    case (time_q[55:48])
      8'h02:   dim = leap ? 8'h29 : 8'h28; // R8
      8'h04, 8'h06, 8'h09, 8'h11: dim = 8'h30; // R8
      default: dim = 8'h31;
    endcase
  end

  // Hour step in 24 or 12 hour mode, bit 5 as PM in 12 hour mode
  always_comb
  begin
    hr_n = hr;
    if (hr[phantom_clock_pkg::HOUR_MODE_BIT])
    begin
      if (hr[4:0] == 5'h12)
        hr_n = {hr[7:5], 5'h01}; // R9
      else if (hr[4:0] == 5'h11)
        hr_n = {hr[7:6], ~hr[5], 5'h12}; // R9
      else if (hr[3:0] == 4'h9)
        hr_n = {hr[7:5], 5'h10};
      else
        hr_n = {hr[7:4], hr[3:0] + 4'h1};
    end
    else if (hr[5:0] >= 6'h23)
      hr_n = {hr[7:6], 6'h00}; // R9
    else if (hr[3:0] == 4'h9)
      hr_n = {hr[7:6], hr[5:4] + 2'h1, 4'h0};
    else
      hr_n = {hr[7:4], hr[3:0] + 4'h1};
  end

  logic hr_w;
  assign hr_w = hr[phantom_clock_pkg::HOUR_MODE_BIT] ? (hr[5] && hr[4:0] == 5'h11)
                                                     : (hr[5:0] >= 6'h23);

  // Time image: ticks win over the buffer drain, which waits; buffered host writes land otherwise
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      time_q <= phantom_clock_pkg::TIME_RESET;
    else if (bw_valid && !tick)
      time_q[bw_data[5:0]] <= bw_data[6]; // R2
    else if (tick)
    begin
      time_q[7:0] <= hu_n; // R7
      if (hu_w)
      begin
        time_q[15:8] <= se_n;
        if (se_w)
        begin
          time_q[23:16] <= mi_n;
          if (mi_w)
          begin
            time_q[31:24] <= hr_n;
            if (hr_w)
            begin
              time_q[34:32] <= dy_n[2:0];
              time_q[47:40] <= dt_n;
              if (dt_w)
              begin
                time_q[55:48] <= mo_n;
                if (mo_w)
                  time_q[63:56] <= yr_n;
              end
            end
          end
        end
      end
    end
  end

  // Assertions
  ce_gated_a: assert property (@(posedge core_clk) disable iff (!rst_n) // R6
    (state_q == ST_XFER || own_q) |-> mem_ce_n) else $error("ce passed during transfer");
  dead_holds_a: assert property (@(posedge core_clk) disable iff (!rst_n) // R17
    (state_q == ST_DEAD && !(cyc_start && rd_cyc) && !pin_abort) |=> state_q == ST_DEAD)
    else $error("dead state left without read");
  read_rewinds_a: assert property (@(posedge core_clk) disable iff (!rst_n) // R14
    (cyc_start && rd_cyc && state_q != ST_XFER && !pin_abort) |=>
    (pos_q == 6'h00 && state_q == ST_MATCH)) else $error("read did not rewind");
  unlock_at_end_a: assert property (@(posedge core_clk) disable iff (!rst_n) // R1
    (cyc_start && state_q == ST_MATCH && !rd_cyc && pos_q == 6'h3F && !pin_abort
     && wr_bit == phantom_clock_pkg::UNLOCK_KEY[63]) |=> state_q == ST_XFER)
    else $error("no unlock after key");
  xfer_release_a: assert property (@(posedge core_clk) disable iff (!rst_n) // R20
    (cyc_start && state_q == ST_XFER && pos_q == 6'h3F && !pin_abort) |=>
    state_q == ST_MATCH && pos_q == 6'h00) else $error("no release after 64 bits");
  abort_a: assert property (@(posedge core_clk) disable iff (!rst_n) // R19
    pin_abort |=> state_q == ST_MATCH && pos_q == 6'h00) else $error("abort ignored");
  tick_space_a: assert property (@(posedge core_clk) disable iff (!rst_n) // R10
    tick |=> !tick) else $error("tick too close");
  bcd_sec_a: assert property (@(posedge core_clk) disable iff (!rst_n) // R16
    (tick && time_q[15:8] == 8'h59 && time_q[7:0] == 8'h99 && !bw_valid) |=>
    time_q[15:8] == 8'h00) else $error("seconds did not wrap");
  wbuf_room_a: assert property (@(posedge core_clk) disable iff (!rst_n) // R2
    wr_valid |-> wr_ready) else $error("write bit lost at full buffer");
  c_unlock: cover property (@(posedge core_clk) disable iff (!rst_n)
    state_q == ST_MATCH ##1 state_q == ST_XFER);
  c_dead: cover property (@(posedge core_clk) disable iff (!rst_n) state_q == ST_DEAD);
  c_wrap: cover property (@(posedge core_clk) disable iff (!rst_n) tick && hu_w && se_w);
endmodule // rom_socket_phantom_clock

// file: tb/host_model.sv
// Host-side model: a processor that reaches the clock socket by read cycles only.
// Assumes the testbench calls xfer one at a time and that core_clk runs throughout.
module host_model (
  input  wire logic core_clk,
  output logic      sock_ce_n,
  output logic      sock_oe_n,
  output logic      read_write_select_addr_bit,
  output logic      serial_write_data_addr_bit,
  input  wire logic serial_read_data_line,
  input  wire logic serial_read_data_line_oe_n,
  input  wire logic mem_ce_n
);
  timeunit 1ns;
  timeprecision 1ns;

  // Idle bus: strobes inactive, address parked on a read slot
  initial
  begin
    sock_ce_n = 1'b1;
    sock_oe_n = 1'b1;
    read_write_select_addr_bit = 1'b1;
    serial_write_data_addr_bit = 1'b0;
  end

  // One socket cycle, or with sel low a foreign cycle; the caller interleaves only foreign cycles into a sequence
  // Address settles three cycles before the strobes, since the pins are synced
  task automatic xfer(input logic rd, input logic wd, input logic sel,
                      output logic dq, output logic mce_n, output logic drv_n);
    @(posedge core_clk);
    #2;
    read_write_select_addr_bit = rd;
    serial_write_data_addr_bit = wd;
    repeat (3) @(posedge core_clk);
    #2;
    sock_ce_n = ~sel;
    sock_oe_n = 1'b0;
    repeat (5) @(posedge core_clk);
    #2;
    drv_n = serial_read_data_line_oe_n;
    // An undriven line would float, so show the inverse rather than a stale value
    dq = drv_n ? ~serial_read_data_line : serial_read_data_line;
    mce_n = mem_ce_n;
    sock_ce_n = 1'b1;
    sock_oe_n = 1'b1;
    repeat (4) @(posedge core_clk);
  endtask
endmodule // host_model

// file: tb/testbench.sv
// Self-checking bench for the ROM-socket clock: unlock, write, read, rollover.
// Assumes the host model above and a shortened tick count for a quick run.
`define check_eq(what, exp, got) \
  begin \
    samples_checked++; \
    if ((got) !== (exp)) \
    begin \
      fails++; \
      $display("unexpected %s expected %h seen %h", what, exp, got); \
    end \
  end

module testbench;
  timeunit 1ns;
  timeprecision 1ns;

  localparam int TICKS = 300;
  localparam int LIMIT = 80000;
  // Oscillator stopped, reset pin disabled, 12 hour mode
  localparam logic [63:0] IMG_A = 64'h9912313791453012;
  // Leap February, one second before midnight, clock running
  localparam logic [63:0] IMG_B = 64'h0402281723595900;
  // Thirtieth of April, 11:59:59.90 PM in 12 hour mode, clock running
  localparam logic [63:0] IMG_C = 64'h99043013B1595990;

  logic        core_clk;
  logic        rst_n;
  logic        clock_reset_pin_n;
  logic        sock_ce_n;
  logic        sock_oe_n;
  logic        read_write_select_addr_bit;
  logic        serial_write_data_addr_bit;
  logic        mem_ce_n;
  logic        serial_read_data_line;
  logic        serial_read_data_line_oe_n;
  logic        clock_unlocked;
  logic        dq;
  logic        mce;
  logic        drv;
  logic [63:0] img;
  int          fails;
  int          samples_checked;
  int          cycles;

  rom_socket_phantom_clock #(.TICK_COUNT(TICKS)) u_rom_socket_phantom_clock (
    .core_clk                   (core_clk),
    .rst_n                      (rst_n),
    .sock_ce_n                  (sock_ce_n),
    .sock_oe_n                  (sock_oe_n),
    .read_write_select_addr_bit (read_write_select_addr_bit),
    .serial_write_data_addr_bit (serial_write_data_addr_bit),
    .clock_reset_pin_n          (clock_reset_pin_n),
    .mem_ce_n                   (mem_ce_n),
    .serial_read_data_line      (serial_read_data_line),
    .serial_read_data_line_oe_n (serial_read_data_line_oe_n),
    .clock_unlocked             (clock_unlocked)
  );

  host_model u_host_model (
    .core_clk                   (core_clk),
    .sock_ce_n                  (sock_ce_n),
    .sock_oe_n                  (sock_oe_n),
    .read_write_select_addr_bit (read_write_select_addr_bit),
    .serial_write_data_addr_bit (serial_write_data_addr_bit),
    .serial_read_data_line      (serial_read_data_line),
    .serial_read_data_line_oe_n (serial_read_data_line_oe_n),
    .mem_ce_n                   (mem_ce_n)
  );

  // Verdict and end of run, shared by the main sequence and the watchdog
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Rewind read, then the key; optional flipped bit, foreign cycle, reset pin pulse
  task automatic send_key(input int bad, input int gap, input int pin);
    logic d, m, v;
    u_host_model.xfer(1'b1, 1'b0, 1'b1, d, m, v);
    for (int i = 0; i < 64; i++)
    begin
      if (i == gap)
        u_host_model.xfer(1'b0, 1'b1, 1'b0, d, m, v);
      if (i == pin)
        #2 clock_reset_pin_n = 1'b0;
      u_host_model.xfer(1'b0, phantom_clock_pkg::UNLOCK_KEY[i] ^ (i == bad), 1'b1, d, m, v);
      if (i == pin)
        #2 clock_reset_pin_n = 1'b1;
    end
  endtask

  // Full 64-bit transfer after the key, register 0 bit 0 first
  task automatic access(input logic rd, input logic [63:0] wimg, output logic [63:0] rimg,
                        input int gap, input int pin);
    logic d, m, v;
    send_key(-1, gap, pin);
    `check_eq("unlocked after key", 1'b1, clock_unlocked)
    for (int i = 0; i < 64; i++)
    begin
      u_host_model.xfer(rd, wimg[i], 1'b1, d, m, v);
      rimg[i] = d;
      `check_eq("memory enable held off", 1'b1, m)
      if (rd)
        `check_eq("data line driven", 1'b0, v)
    end
    `check_eq("released after data", 1'b0, clock_unlocked)
  endtask

  // 50 ns period
  always #25 core_clk = ~core_clk;

  // Watchdog against a hung handshake
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == LIMIT)
    begin
      fails++;
      $display("unexpected timeout expected %0d seen %0d", LIMIT, cycles);
      complete_run();
    end
  end

  // Main sequence
  initial
  begin
    core_clk = 1'b0;
    rst_n = 1'b0;
    clock_reset_pin_n = 1'b1;
    fails = 0;
    samples_checked = 0;
    cycles = 0;
    repeat (5) @(posedge core_clk);
    #2;
    rst_n = 1'b1;
    `check_eq("idle chip enable", 1'b1, mem_ce_n)
    u_host_model.xfer(1'b1, 1'b0, 1'b1, dq, mce, drv);
    `check_eq("pass-through chip enable", 1'b0, mce)
    `check_eq("no drive while locked", 1'b1, drv)
    send_key(10, -1, -1);
    `check_eq("locked after bad key bit", 1'b0, clock_unlocked)
    // Reset pin still honoured here: the disable bit is clear after reset
    send_key(-1, -1, 40);
    `check_eq("abort before unlock", 1'b0, clock_unlocked)
    // First write may race running ticks; the second lands on a stopped clock
    access(1'b0, IMG_A, img, -1, -1);
    access(1'b0, IMG_A, img, 20, -1);
    access(1'b1, '0, img, -1, 30);
    `check_eq("stopped image", IMG_A, img)
    access(1'b0, IMG_B, img, -1, -1);
    repeat (130 * TICKS) @(posedge core_clk);
    access(1'b1, '0, img, -1, -1);
    `check_eq("leap rollover image", 56'h04022911000000, img[63:8])
    `check_eq("hundredths pace", 1'b1, img[7:0] >= 8'h28 && img[7:0] <= 8'h38)
    // Rollover lands before the read key ends, so upper registers are settled
    access(1'b0, IMG_C, img, -1, -1);
    repeat (10 * TICKS) @(posedge core_clk);
    access(1'b1, '0, img, -1, -1);
    `check_eq("twelve hour rollover image", 56'h99050114920000, img[63:8])
    `check_eq("short month date", 8'h01, img[47:40])
    complete_run();
  end
endmodule // testbench
